// File: cpm_chk.sv
// port assertions for the clock prescaler and power-mode block
`timescale 1ns/1ps
module cpm_chk
  import cpm_pkg::*;
#(
  parameter int PRESC_W = 13,
  parameter int N_MOD = 8
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic pslverr,
  input wire logic sleep_exec,
  input wire logic subsleep_sel,
  input wire logic wake_irq,
  input wire logic sys_tick,
  input wire logic [PRESC_W-1:0] presc_taps,
  input wire cpm_run_t run,
  input wire logic [N_MOD-1:0] module_run
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);
  logic [6:0] gap_q;
  // cycles since the last tick, saturating so a stuck divider cannot wrap
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) gap_q <= 7'h00;
    else if (sys_tick || !run.periph_run) gap_q <= 7'h00;
    else if (gap_q != 7'h7f) gap_q <= gap_q + 7'h01;
  end
  // the clear lands one cycle after the halt enables drop
  chk_presc_clear: assert property (!run.periph_run
    && !$fell(run.periph_run) |-> presc_taps == '0)
    else $error("prescaler not cleared while halted");
  chk_presc_step: assert property ($changed(presc_taps) && presc_taps != '0
    |-> presc_taps == $past(presc_taps) + 13'h0001)
    else $error("prescaler moved by other than one");
  // last tick of the old mode may still show in the first halted cycle
  chk_tick_halt: assert property ($fell(run.periph_run) && !wake_irq
    |=> !sys_tick [*2]) else $error("tick running after halt");
  chk_cpu_periph: assert property (run.cpu_run |-> run.periph_run
    && !run.io_hold) else $error("cpu runs without peripherals");
  chk_sleep_entry: assert property (sleep_exec && run.cpu_run
    |=> !run.cpu_run) else $error("sleep instruction ignored");
  chk_subsleep_hold: assert property (sleep_exec && run.cpu_run
    && subsleep_sel |=> run.io_hold) else $error("ports not held");
  chk_tick_gap: assert property (run.periph_run |-> gap_q <= 7'd64)
    else $error("tick gap beyond largest ratio");
  chk_wake_hold: assert property (wake_irq && !run.periph_run
    |=> !run.cpu_run [*8]) else $error("cpu released before wait");
  chk_mstop_off: assert property (!run.periph_run |-> module_run == '0)
    else $error("module enable while peripherals halted");
  cover property (sleep_exec && run.cpu_run);
  cover property (wake_irq && !run.periph_run);
  cover property (run.io_hold);
  cover property (pslverr);
endmodule
bind cpm_top cpm_chk #(.PRESC_W(PRESC_W), .N_MOD(N_MOD)) cpm_chk_inst (
  .clk(clk), .rstn(rstn), .pslverr(pslverr), .sleep_exec(sleep_exec),
  .subsleep_sel(subsleep_sel), .wake_irq(wake_irq), .sys_tick(sys_tick),
  .presc_taps(presc_taps), .run(run), .module_run(module_run));

// File: cpm_pkg.sv
// constants, types and helpers for the clock prescaler and power-mode block
// Summary of operation
// - prescaler taps give phi/2 to phi/8192
// - 13-bit up-counter, one step per clock
// - reset clears prescaler, counts after release
// - standby and subsleep halt and clear prescaler
// - prescaler count hidden from software
// - shared taps, each peripheral picks own ratio
// - prescaler clock is divided oscillator clock
// - system clock: osc, /8, /16, /32, /64
// - sleep stops processor, peripherals keep running
// - standby/subsleep halt all; subsleep holds ports
// - unused modules stop one at a time
// - sleep instruction: select bit picks sleep/standby
// - three-bit field sets wake stabilisation wait
// - control bits reset zero, low nibble reads zero
// - wait encodings 8192..131072, 1024, 128, 16 states
// - divide change applies after sleep instruction
package cpm_pkg;

  // register byte addresses
  localparam logic [11:0] CPM_ADDR_CTRL_ONE = 12'h000;
  localparam logic [11:0] CPM_ADDR_CTRL_TWO = 12'h004;
  localparam logic [11:0] CPM_ADDR_MSTOP = 12'h008;
  localparam logic [11:0] CPM_ADDR_STATUS = 12'h00c;

  // field positions
  localparam int CPM_STBY_BIT = 7;
  localparam int CPM_WAIT_LSB = 4;
  localparam int CPM_DIV_LSB = 2;
  localparam logic [2:0] CPM_CTRL_RESET = 3'h0;
  localparam logic [3:0] CPM_RSVD_ZERO = 4'h0;

  // divider ratios of the system clock enable
  localparam logic [6:0] CPM_RATIO_1 = 7'h01;
  localparam logic [6:0] CPM_RATIO_8 = 7'h08;
  localparam logic [6:0] CPM_RATIO_16 = 7'h10;
  localparam logic [6:0] CPM_RATIO_32 = 7'h20;
  localparam logic [6:0] CPM_RATIO_64 = 7'h40;

  // short wake waits; long ones are top-level parameters
  localparam logic [17:0] CPM_WAIT_1024 = 18'h00400;
  localparam logic [17:0] CPM_WAIT_128 = 18'h00080;
  localparam logic [17:0] CPM_WAIT_16 = 18'h00010;

  typedef enum logic [2:0] {
    CPM_ACTIVE,
    CPM_SLEEP,
    CPM_STANDBY,
    CPM_SUBSLEEP,
    CPM_WAKE_WAIT
  } cpm_mode_t;

  // apb request from the master
  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
  } cpm_apb_req_t;

  // clock enables handed to the rest of the chip
  typedef struct packed {
    logic cpu_run;
    logic periph_run;
    logic io_hold;
  } cpm_run_t;

  // 0xx undivided, 100 /8, 101 /16, 110 /32, 111 /64
  function automatic logic [6:0] cpm_ratio(input logic [2:0] sel);
    logic [6:0] r;
    r = CPM_RATIO_1;
    if (sel == 3'h4) r = CPM_RATIO_8;
    else if (sel == 3'h5) r = CPM_RATIO_16;
    else if (sel == 3'h6) r = CPM_RATIO_32;
    else if (sel == 3'h7) r = CPM_RATIO_64;
    return r;
  endfunction

endpackage

// File: cpm_prescaler.sv
// free-running system prescaler with halt-and-clear
`timescale 1ns/1ps
module cpm_prescaler
  import cpm_pkg::*;
#(
  parameter int WIDTH = 13
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic tick,
  input wire logic halt,
  output logic [WIDTH-1:0] count
);

  initial begin
    if (WIDTH < 2) $error("prescaler needs at least two bits");
  end

  logic [WIDTH-1:0] count_q;
  logic [WIDTH-1:0] count_d;

  // halt wins over tick so a frozen prescaler always restarts at zero
  assign count_d = halt ? '0 : (tick ? count_q + 1'b1 : count_q);

  // no software path reaches this counter
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) count_q <= '0;
    else count_q <= count_d;
  end

  assign count = count_q;
endmodule

// File: cpm_top.sv
// clock prescaler and power-mode controller with apb registers
//
// Our own choices: the placing of the registers and the APB interface to the registers.
`timescale 1ns/1ps
module cpm_top
  import cpm_pkg::*;
#(
  parameter int PRESC_W = 13,
  parameter int N_MOD = 8,
  parameter logic [17:0] WAIT_8192 = 18'h02000,
  parameter logic [17:0] WAIT_16384 = 18'h04000,
  parameter logic [17:0] WAIT_32768 = 18'h08000,
  parameter logic [17:0] WAIT_65536 = 18'h10000,
  parameter logic [17:0] WAIT_131072 = 18'h20000
) (
  input wire logic clk,
  input wire logic rstn,
  input wire cpm_apb_req_t apb_req,
  output logic pready,
  output logic [31:0] prdata,
  output logic pslverr,
  input wire logic sleep_exec,
  input wire logic subsleep_sel,
  input wire logic wake_irq,
  output logic sys_tick,
  output logic [PRESC_W-1:0] presc_taps,
  output cpm_run_t run,
  output logic [N_MOD-1:0] module_run
);

  initial begin
    if (PRESC_W != 13) $error("prescaler taps fixed at thirteen bits");
    if (N_MOD < 1 || N_MOD > 32) $error("module count must be 1..32");
  end

  // ---------------- register state ----------------
  logic stby_sel_q;
  logic [2:0] wait_sel_q;
  logic [2:0] div_pend_q;
  logic [2:0] div_eff_q;
  logic [N_MOD-1:0] mstop_q;
  cpm_mode_t mode_q;
  cpm_mode_t mode_d;

  // apb decode
  wire acc = apb_req.psel && apb_req.penable;
  wire wr = acc && apb_req.pwrite;
  wire hit_one = (apb_req.paddr == CPM_ADDR_CTRL_ONE);
  wire hit_two = (apb_req.paddr == CPM_ADDR_CTRL_TWO);
  wire hit_mst = (apb_req.paddr == CPM_ADDR_MSTOP);
  wire hit_sts = (apb_req.paddr == CPM_ADDR_STATUS);
  wire hit_any = hit_one || hit_two || hit_mst || hit_sts;
  wire sleep_go = sleep_exec && (mode_q == CPM_ACTIVE);

  // zero-wait slave: every access completes in its first access cycle
  assign pready = 1'b1;
  assign pslverr = acc && !hit_any;

  // control register one
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      stby_sel_q <= 1'b0;
      wait_sel_q <= CPM_CTRL_RESET;
    end else if (wr && hit_one) begin
      stby_sel_q <= apb_req.pwdata[CPM_STBY_BIT];
      wait_sel_q <= apb_req.pwdata[CPM_WAIT_LSB +: 3];
    end
  end

  // divide setting is staged; it reaches the divider only on sleep
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      div_pend_q <= CPM_CTRL_RESET;
      div_eff_q <= CPM_CTRL_RESET;
    end else begin
      if (wr && hit_two) div_pend_q <= apb_req.pwdata[CPM_DIV_LSB +: 3];
      if (sleep_go) div_eff_q <= div_pend_q;
    end
  end

  // module stop bits, one per peripheral
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) mstop_q <= '0;
    else if (wr && hit_mst) mstop_q <= apb_req.pwdata[N_MOD-1:0];
  end

  // read mux; prescaler count has no address at all
  logic [31:0] rd_val;
  wire [31:0] rd_one = {24'h000000, stby_sel_q, wait_sel_q, CPM_RSVD_ZERO};
  wire [31:0] rd_two = {27'h0000000, div_pend_q, 2'h0};
  wire [31:0] rd_mst = {{(32-N_MOD){1'b0}}, mstop_q};
  wire [31:0] rd_sts = {26'h0000000, div_eff_q, mode_q};
  always_comb begin
    if (hit_one) rd_val = rd_one;
    else if (hit_two) rd_val = rd_two;
    else if (hit_mst) rd_val = rd_mst;
    else if (hit_sts) rd_val = rd_sts;
    else rd_val = 32'h00000000;
  end

  // data output registered in the setup cycle, so it already stands
  // through the access cycle in which the master takes it
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) prdata <= 32'h00000000;
    else if (apb_req.psel && !apb_req.penable && !apb_req.pwrite) begin
      prdata <= rd_val;
    end
  end

  // ---------------- system clock divider ----------------
  logic [6:0] div_cnt_q;
  logic [6:0] div_cnt_d;
  logic tick_d;
  wire [6:0] ratio = cpm_ratio(div_eff_q);
  wire osc_halt = (mode_q == CPM_STANDBY) || (mode_q == CPM_SUBSLEEP);

  // enable pulse once every ratio oscillator cycles; stopped when halted;
  // compare with >= so a smaller new ratio never waits for a counter wrap
  assign tick_d = !osc_halt && (div_cnt_q >= ratio - 7'h01);
  assign div_cnt_d = (osc_halt || tick_d) ? 7'h00 : div_cnt_q + 7'h01;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      div_cnt_q <= 7'h00;
      sys_tick <= 1'b0;
    end else begin
      div_cnt_q <= div_cnt_d;
      sys_tick <= tick_d;
    end
  end

  // ---------------- wake wait ----------------
  logic [17:0] wait_states;
  always_comb begin
    case (wait_sel_q)
      3'h0: wait_states = WAIT_8192;
      3'h1: wait_states = WAIT_16384;
      3'h2: wait_states = WAIT_32768;
      3'h3: wait_states = WAIT_65536;
      3'h4: wait_states = WAIT_131072;
      3'h5: wait_states = CPM_WAIT_1024;
      3'h6: wait_states = CPM_WAIT_128;
      default: wait_states = CPM_WAIT_16;
    endcase
  end

  wire wake_start = wake_irq && osc_halt;
  logic wake_done;

  // counting uses system clock states, so the divided clock paces it;
  // software must size the field for at least 6.5 ms
  cpm_wake_timer #(
    .WIDTH(18)
  ) u_wake (
    .clk(clk),
    .rstn(rstn),
    .start(wake_start),
    .tick(sys_tick),
    .states(wait_states),
    .busy(),
    .done(wake_done)
  );

  // ---------------- mode machine ----------------
  always_comb begin
    mode_d = mode_q;
    case (mode_q)
      CPM_ACTIVE: begin
        if (sleep_exec) begin
          if (subsleep_sel) mode_d = CPM_SUBSLEEP;
          else if (stby_sel_q) mode_d = CPM_STANDBY;
          else mode_d = CPM_SLEEP;
        end
      end
      CPM_SLEEP: begin
        if (wake_irq) mode_d = CPM_ACTIVE;
      end
      CPM_STANDBY, CPM_SUBSLEEP: begin
        if (wake_irq) mode_d = CPM_WAKE_WAIT;
      end
      CPM_WAKE_WAIT: begin
        if (wake_done) mode_d = CPM_ACTIVE;
      end
      default: mode_d = CPM_ACTIVE;
    endcase
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) mode_q <= CPM_ACTIVE;
    else mode_q <= mode_d;
  end

  // ---------------- prescaler ----------------
  // also held clear through the wake wait so peripherals restart clean
  wire presc_halt = osc_halt || (mode_q == CPM_WAKE_WAIT);

  cpm_prescaler #(
    .WIDTH(PRESC_W)
  ) u_presc (
    .clk(clk),
    .rstn(rstn),
    .tick(sys_tick),
    .halt(presc_halt),
    .count(presc_taps)
  );

  // ---------------- run enables ----------------
  wire cpu_d = (mode_d == CPM_ACTIVE);
  wire per_d = (mode_d == CPM_ACTIVE) || (mode_d == CPM_SLEEP);
  wire hold_d = (mode_d == CPM_SUBSLEEP);

  // registered from the next mode so enables change with the state
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      run <= '{cpu_run: 1'b1, periph_run: 1'b1, io_hold: 1'b0};
      module_run <= '1;
    end else begin
      run <= '{cpu_run: cpu_d, periph_run: per_d, io_hold: hold_d};
      module_run <= {N_MOD{per_d}} & ~mstop_q;
    end
  end

endmodule

// File: cpm_top_test.sv
// self-checking bench for the clock prescaler and power-mode block
`timescale 1ns/1ps
module cpm_top_test;
  import cpm_pkg::*;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  cpm_apb_req_t req = '0;
  logic sleep_exec = 1'b0;
  logic subsleep_sel = 1'b0;
  logic wake_irq = 1'b0;
  logic pready, pslverr, sys_tick, e;
  logic [31:0] prdata, q;
  logic [12:0] presc_taps, p0;
  logic [2:0] pv = 3'h0;
  cpm_run_t run;
  logic [7:0] module_run;
  int n_mismatch = 0;
  int n_compared = 0;
  int n, k;
  int wt[8] = '{32, 48, 64, 80, 96, 1024, 128, 16};
  int rt[8] = '{1, 1, 1, 1, 8, 16, 32, 64};
  always #4 clk = ~clk;
  // short long-wait values keep the run brief
  cpm_top #(.WAIT_8192(18'h00020), .WAIT_16384(18'h00030),
    .WAIT_32768(18'h00040), .WAIT_65536(18'h00050),
    .WAIT_131072(18'h00060)) cpm_top_inst (.clk(clk), .rstn(rstn),
    .apb_req(req), .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .sleep_exec(sleep_exec), .subsleep_sel(subsleep_sel),
    .wake_irq(wake_irq), .sys_tick(sys_tick), .presc_taps(presc_taps),
    .run(run), .module_run(module_run));
  task summarize();
    $display("compared %0d mismatches %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_mismatch++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // one apb transfer; read data stands in the access cycle, taken at its edge
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int i;
    @(posedge clk);
    req <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: d};
    @(posedge clk);
    req.penable <= 1'b1;
    for (i = 0; i < 20; i++) begin
      @(posedge clk);
      if (pready === 1'b1) break;
    end
    if (i == 20) begin
      n_mismatch++;
      summarize();
    end
    e = pslverr;
    q = prdata;
    req.psel <= 1'b0;
    req.penable <= 1'b0;
    // idle cycle so registered outputs settle before the caller looks
    @(posedge clk);
    #1;
  endtask
  task sleep_go(input logic s);
    @(posedge clk);
    subsleep_sel <= s;
    sleep_exec <= 1'b1;
    @(posedge clk);
    sleep_exec <= 1'b0;
    subsleep_sel <= 1'b0;
    @(posedge clk);
    #1;
  endtask
  // cycles from the wake pulse until the cpu is released
  task wake();
    @(posedge clk);
    wake_irq <= 1'b1;
    @(posedge clk);
    wake_irq <= 1'b0;
    for (n = 0; n < 5000; n++) begin
      @(posedge clk);
      #1;
      if (run.cpu_run === 1'b1) break;
    end
    if (n == 5000) begin
      n_mismatch++;
      summarize();
    end
  endtask
  task ticks(input int c);
    k = 0;
    repeat (c) begin
      @(posedge clk);
      #1;
      k += int'(sys_tick === 1'b1);
    end
  endtask
  initial begin
    repeat (5) @(posedge clk);
    chk(presc_taps, 0);
    rstn <= 1'b1;
    apb(1'b0, 12'h000, 0); chk(q, 0);
    apb(1'b1, 12'h000, 32'hff); apb(1'b0, 12'h000, 0); chk(q, 32'hf0);
    apb(1'b0, 12'h010, 0);
    chk(q, 0);
    chk(32'(e), 1);
    apb(1'b1, 12'h00c, 32'hff); apb(1'b0, 12'h00c, 0); chk(q, 0);
    apb(1'b1, 12'h008, 32'h05); chk(module_run, 8'hfa);
    apb(1'b1, 12'h000, 0);
    // every divide code: pending until the sleep instruction, then in effect
    for (int c = 0; c < 8; c++) begin
      apb(1'b1, 12'h004, 32'(c) << 2);
      apb(1'b0, 12'h00c, 0); chk(q, {26'h0, pv, 3'h0});
      sleep_go(1'b0); chk(run, 3'b010);
      ticks(64); p0 = presc_taps;
      ticks(128); chk(k, 128 / rt[c]);
      chk(13'(presc_taps - p0), 128 / rt[c]);
      wake();
      pv = 3'(c);
    end
    apb(1'b1, 12'h004, 0);
    // every wait code through standby, undivided
    for (int c = 0; c < 8; c++) begin
      apb(1'b1, 12'h000, 32'h80 | (32'(c) << 4));
      sleep_go(1'b0); chk({run, presc_taps}, 16'h0);
      wake(); chk(n >= wt[c] - 2 && n <= wt[c] + 4, 1);
    end
    apb(1'b1, 12'h000, 32'h70);
    sleep_go(1'b1); chk(run, 3'b001);
    apb(1'b0, 12'h00c, 0); chk(q, 32'h3);
    wake(); chk(run, 3'b110);
    chk(module_run, 8'hfa);
    summarize();
  end
endmodule

// File: cpm_wake_timer.sv
// oscillator stabilisation wait counter
`timescale 1ns/1ps
module cpm_wake_timer
  import cpm_pkg::*;
#(
  parameter int WIDTH = 18
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic start,
  input wire logic tick,
  input wire logic [WIDTH-1:0] states,
  output logic busy,
  output logic done
);

  initial begin
    if (WIDTH < 5) $error("wake timer too narrow");
  end

  logic [WIDTH-1:0] cnt_q;
  logic busy_q;
  logic last;

  assign last = busy_q && tick && (cnt_q == '0);

  // load n-1 so exactly n system clock states pass
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      cnt_q <= '0;
      busy_q <= 1'b0;
    end else if (start) begin
      cnt_q <= states - 1'b1;
      busy_q <= 1'b1;
    end else if (last) begin
      busy_q <= 1'b0;
    end else if (busy_q && tick) begin
      cnt_q <= cnt_q - 1'b1;
    end
  end

  assign busy = busy_q;
  assign done = last;
endmodule
